// ==== core/nhc_pkg.sv ====
// Purpose: Shared constants and types for the NAND bus host controller
// Assumes: 40 MHz system clock, byte-wide multiplexed flash bus
// Notes: Pin timings are least times, rounded up to whole clock cycles
`default_nettype none

package nhc_pkg;

	// Clock rate
	localparam int NHC_CLK_MHZ = 40;
	localparam int NHC_NS_PER_US = 1000;

	// Bus timing in nanoseconds (plain defaults, tune per part)
	localparam int NHC_WE_LOW_NS = 25;
	localparam int NHC_WE_HOLD_NS = 25;
	localparam int NHC_READ_ACCESS_DELAY_NS = 20;
	localparam int NHC_RE_HIGH_NS = 25;
	localparam int NHC_BUSY_SETTLE_NS = 100;

	// Least times round up to whole cycles, never below one
	function automatic int nhc_cycles_up(input int ns);
		int c;
		c = (ns * NHC_CLK_MHZ + NHC_NS_PER_US - 1) / NHC_NS_PER_US;
		return (c < 1) ? 1 : c;
	endfunction : nhc_cycles_up

	localparam int NHC_SYNC_STAGES = 2;
	localparam int NHC_CNT_W = 4;
	localparam logic [NHC_CNT_W-1:0] NHC_WE_LOW_CYC = NHC_CNT_W'(nhc_cycles_up(NHC_WE_LOW_NS));
	localparam logic [NHC_CNT_W-1:0] NHC_WE_HOLD_CYC = NHC_CNT_W'(nhc_cycles_up(NHC_WE_HOLD_NS));
	// Strobe low long enough for access delay plus the input synchroniser
	localparam logic [NHC_CNT_W-1:0] NHC_RE_LOW_CYC =
		NHC_CNT_W'(nhc_cycles_up(NHC_READ_ACCESS_DELAY_NS) + NHC_SYNC_STAGES + 1);
	localparam logic [NHC_CNT_W-1:0] NHC_RE_HIGH_CYC = NHC_CNT_W'(nhc_cycles_up(NHC_RE_HIGH_NS));
	localparam logic [NHC_CNT_W-1:0] NHC_SETTLE_CYC =
		NHC_CNT_W'(nhc_cycles_up(NHC_BUSY_SETTLE_NS));
	localparam logic [NHC_CNT_W-1:0] NHC_CNT_ONE = NHC_CNT_W'(1);

	// Address layout
	localparam int NHC_BYTE_W = 8;
	localparam int NHC_COL_W = 12;
	localparam int NHC_ROW_W = 18;
	localparam int NHC_PLANE_BIT = 6;
	localparam int NHC_IDX_W = 3;
	localparam logic [NHC_IDX_W-1:0] NHC_AC_COL_LO = 3'h0;
	localparam logic [NHC_IDX_W-1:0] NHC_AC_COL_HI = 3'h1;
	localparam logic [NHC_IDX_W-1:0] NHC_AC_ROW_LO = 3'h2;
	localparam logic [NHC_IDX_W-1:0] NHC_AC_ROW_MID = 3'h3;
	localparam logic [NHC_IDX_W-1:0] NHC_AC_ROW_HI = 3'h4;

	typedef logic [NHC_BYTE_W-1:0] nhc_byte_type;

	// Defined command codes; program and erase codes are a leading subset
	localparam int NHC_N_CMD = 25;
	localparam int NHC_N_PE = 9;
	localparam nhc_byte_type NHC_CMD_SET [NHC_N_CMD] = '{
		8'h80, 8'h85, 8'h81, 8'h10, 8'h15, 8'h11, 8'h60, 8'hD0, 8'hD1,
		8'h00, 8'h30, 8'h35, 8'h31, 8'h3F, 8'h90, 8'h70, 8'hFF, 8'h05,
		8'hE0, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'h78, 8'h06};

	// User operation codes
	typedef enum logic [2:0] {
		NHC_OP_CMD,
		NHC_OP_ADDR,
		NHC_OP_WDATA,
		NHC_OP_RDATA,
		NHC_OP_WAIT
	} nhc_op_type;

	// Controller states
	typedef enum logic [2:0] {
		NHC_ST_IDLE,
		NHC_ST_SETUP,
		NHC_ST_WE_LOW,
		NHC_ST_WE_HIGH,
		NHC_ST_RE_LOW,
		NHC_ST_RE_HIGH,
		NHC_ST_SETTLE,
		NHC_ST_RB_WAIT
	} nhc_state_type;

endpackage : nhc_pkg

`default_nettype wire

// ==== core/nhc_addr_if.sv ====
// Purpose: Carries address fields and the formatted cycle byte
// Assumes: Formatter is purely combinational
// Notes: One modport per side
`default_nettype none

interface nhc_addr_if;
	import nhc_pkg::*;
	logic [NHC_COL_W-1:0] column;
	logic [NHC_ROW_W-1:0] row;
	logic [NHC_IDX_W-1:0] cycle;
	nhc_byte_type addr_byte;
	logic plane;

	modport fmt (input column, input row, input cycle, output addr_byte, output plane);
	modport user (output column, output row, output cycle, input addr_byte, input plane);
endinterface : nhc_addr_if

`default_nettype wire

// ==== core/nhc_addr_fmt.sv ====
// Purpose: Maps column and row address onto the five address bus cycles
// Assumes: Cycle index is held stable by the caller
// Notes: Unused upper lines of partial cycles are always driven low
`default_nettype none

module nhc_addr_fmt
	import nhc_pkg::*;
(
	nhc_addr_if.fmt a
);

	assign a.plane = a.row[NHC_PLANE_BIT];

	// Byte for each address cycle, zero-extended partial cycles
	always_comb begin
		unique case (a.cycle)
			NHC_AC_COL_LO: a.addr_byte = a.column[NHC_BYTE_W-1:0];
			// column bits above, upper lines low
			NHC_AC_COL_HI: a.addr_byte = nhc_byte_type'(a.column[NHC_COL_W-1:NHC_BYTE_W]);
			NHC_AC_ROW_LO: a.addr_byte = a.row[NHC_BYTE_W-1:0];
			NHC_AC_ROW_MID: a.addr_byte = a.row[2*NHC_BYTE_W-1:NHC_BYTE_W];
			// top row bits, upper lines low
			NHC_AC_ROW_HI: a.addr_byte = nhc_byte_type'(a.row[NHC_ROW_W-1:2*NHC_BYTE_W]);
			default: a.addr_byte = '0;
		endcase
	end

endmodule : nhc_addr_fmt

`default_nettype wire

// ==== core/nhc_host.sv ====
// Purpose: Host controller driving a NAND flash through its strobe pins
// Assumes: One request at a time; device ready line pulled up outside
// Notes: Every pin input passes a two-stage synchroniser before use
`default_nettype none

// Operation
// - bytes valid across write strobe rising edge
// - busy line is open drain, pulled up
// - column in two cycles, low first
// - row in three cycles, low first
// - unused upper lines driven low
// - undefined command codes are refused
module nhc_host
	import nhc_pkg::*;
#(
	parameter int ADDR_CYCLES = 5
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire nhc_op_type REQ_OP,
	input wire nhc_byte_type REQ_BYTE,
	input wire logic [NHC_COL_W-1:0] REQ_COLUMN,
	input wire logic [NHC_ROW_W-1:0] REQ_ROW,
	input wire logic REQ_KEEP_SEL,
	input wire logic PROGRAM_ENABLE,
	output logic RSP_VALID,
	output logic RSP_ERR,
	output nhc_byte_type RSP_BYTE,
	output logic DEVICE_READY,
	output logic CHIP_SELECT_N,
	output logic CMD_LATCH_SEL,
	output logic ADDR_LATCH_SEL,
	output logic WRITE_STROBE_N,
	output logic READ_STROBE_N,
	output logic WRITE_GUARD_N,
	input wire logic READY_BUSY_N,
	input wire nhc_byte_type IO_BUS_IN,
	output nhc_byte_type IO_BUS_OUT,
	output logic IO_BUS_OE
);

	localparam logic [NHC_IDX_W-1:0] LAST_IDX = NHC_IDX_W'(ADDR_CYCLES - 1);

	typedef struct packed {
		nhc_state_type state;
		logic [NHC_CNT_W-1:0] cnt;
		logic [NHC_IDX_W-1:0] idx;
		nhc_op_type op;
		nhc_byte_type wbyte;
		logic [NHC_COL_W-1:0] column;
		logic [NHC_ROW_W-1:0] row;
		logic keep;
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic guard_n;
		logic oe;
		nhc_byte_type dout;
		nhc_byte_type rbyte;
		logic rsp;
		logic err;
		nhc_byte_type io_s1;
		nhc_byte_type io_s2;
		logic rb_s1;
		logic rb_s2;
	} nhc_regs_type;

	nhc_regs_type r_q;
	nhc_regs_type r_d;

	nhc_addr_if aif ();

	nhc_addr_fmt u_fmt (
		.a(aif.fmt)
	);

	assign aif.column = r_q.column;
	assign aif.row = r_q.row;
	assign aif.cycle = r_q.idx;

	// Command code lookup against the defined set
	function automatic logic cmd_known(input nhc_byte_type c);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NHC_N_CMD; i++) begin
			if (NHC_CMD_SET[i] == c) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : cmd_known

	function automatic logic cmd_prog_erase(input nhc_byte_type c);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NHC_N_PE; i++) begin
			if (NHC_CMD_SET[i] == c) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : cmd_prog_erase

	// Next-state logic for the whole controller
	always_comb begin
		r_d = r_q;
		r_d.rsp = 1'b0;
		// Pin synchronisers, first stage feeds only the second
		r_d.io_s1 = IO_BUS_IN;
		r_d.io_s2 = r_q.io_s1;
		r_d.rb_s1 = READY_BUSY_N;
		r_d.rb_s2 = r_q.rb_s1;
		unique case (r_q.state)
			NHC_ST_IDLE: begin
				// Guard only changes between operations to avoid mid-cycle glitches
				r_d.guard_n = PROGRAM_ENABLE;
				if (REQ_VALID) begin
					r_d.op = REQ_OP;
					r_d.wbyte = REQ_BYTE;
					r_d.column = REQ_COLUMN;
					r_d.row = REQ_ROW;
					r_d.keep = REQ_KEEP_SEL;
					r_d.idx = '0;
					r_d.err = 1'b0;
					if (REQ_OP == NHC_OP_CMD && !cmd_known(REQ_BYTE)) begin
						r_d.err = 1'b1;
					end
					if (!r_q.guard_n && ((REQ_OP == NHC_OP_CMD && cmd_prog_erase(REQ_BYTE))
						|| REQ_OP == NHC_OP_WDATA)) begin
						r_d.err = 1'b1;
					end
					if (r_d.err) begin
						r_d.rsp = 1'b1;
					end else if (REQ_OP == NHC_OP_WAIT) begin
						r_d.cnt = NHC_SETTLE_CYC - NHC_CNT_ONE;
						r_d.state = NHC_ST_SETTLE;
					end else begin
						r_d.state = NHC_ST_SETUP;
					end
				end
			end
			NHC_ST_SETUP: begin
				r_d.ce_n = 1'b0;
				if (r_q.op == NHC_OP_RDATA) begin
					// latch selects low, write strobe high
					r_d.cle = 1'b0;
					r_d.ale = 1'b0;
					r_d.oe = 1'b0;
					r_d.re_n = 1'b0;
					r_d.cnt = NHC_RE_LOW_CYC - NHC_CNT_ONE;
					r_d.state = NHC_ST_RE_LOW;
				end else begin
					r_d.cle = (r_q.op == NHC_OP_CMD);
					r_d.ale = (r_q.op == NHC_OP_ADDR);
					// data cycle has both selects low
					r_d.oe = 1'b1;
					r_d.dout = (r_q.op == NHC_OP_ADDR) ? aif.addr_byte : r_q.wbyte;
					r_d.we_n = 1'b0;
					r_d.cnt = NHC_WE_LOW_CYC - NHC_CNT_ONE;
					r_d.state = NHC_ST_WE_LOW;
				end
			end
			NHC_ST_WE_LOW: begin
				r_d.cnt = r_q.cnt - NHC_CNT_ONE;
				if (r_q.cnt == '0) begin
					// rising edge with byte still driven
					r_d.we_n = 1'b1;
					r_d.cnt = NHC_WE_HOLD_CYC - NHC_CNT_ONE;
					r_d.state = NHC_ST_WE_HIGH;
				end
			end
			NHC_ST_WE_HIGH: begin
				r_d.cnt = r_q.cnt - NHC_CNT_ONE;
				if (r_q.cnt == '0) begin
					// stop after the last address cycle
					if (r_q.op == NHC_OP_ADDR && r_q.idx != LAST_IDX) begin
						r_d.idx = r_q.idx + NHC_IDX_W'(1);
						r_d.state = NHC_ST_SETUP;
					end else begin
						r_d.cle = 1'b0;
						r_d.ale = 1'b0;
						r_d.oe = 1'b0;
						r_d.rsp = 1'b1;
						r_d.ce_n = !r_q.keep;
						r_d.state = NHC_ST_IDLE;
					end
				end
			end
			NHC_ST_RE_LOW: begin
				r_d.cnt = r_q.cnt - NHC_CNT_ONE;
				if (r_q.cnt == '0) begin
					// sample after access delay and sync
					r_d.rbyte = r_q.io_s2;
					// one strobe per byte, device steps column
					r_d.re_n = 1'b1;
					r_d.cnt = NHC_RE_HIGH_CYC - NHC_CNT_ONE;
					r_d.state = NHC_ST_RE_HIGH;
				end
			end
			NHC_ST_RE_HIGH: begin
				r_d.cnt = r_q.cnt - NHC_CNT_ONE;
				if (r_q.cnt == '0) begin
					r_d.rsp = 1'b1;
					r_d.ce_n = !r_q.keep;
					r_d.state = NHC_ST_IDLE;
				end
			end
			NHC_ST_SETTLE: begin
				// Busy line may lag the last strobe, so wait before looking
				r_d.cnt = r_q.cnt - NHC_CNT_ONE;
				if (r_q.cnt == '0) begin
					r_d.state = NHC_ST_RB_WAIT;
				end
			end
			NHC_ST_RB_WAIT: begin
				if (r_q.rb_s2) begin
					r_d.rsp = 1'b1;
					r_d.ce_n = !r_q.keep;
					r_d.state = NHC_ST_IDLE;
				end
			end
		endcase
	end

	// State register, synchronous reset
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			r_q <= '0;
			r_q.state <= NHC_ST_IDLE;
			r_q.op <= NHC_OP_CMD;
			r_q.ce_n <= 1'b1;
			r_q.we_n <= 1'b1;
			r_q.re_n <= 1'b1;
			r_q.rb_s1 <= 1'b1;
			r_q.rb_s2 <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// Pin and user outputs straight from flip-flops, REQ_READY decoded from the state register
	assign REQ_READY = (r_q.state == NHC_ST_IDLE);
	assign RSP_VALID = r_q.rsp;
	assign RSP_ERR = r_q.err;
	assign RSP_BYTE = r_q.rbyte;
	// pulled-up line reads high when ready
	assign DEVICE_READY = r_q.rb_s2;
	assign CHIP_SELECT_N = r_q.ce_n;
	assign CMD_LATCH_SEL = r_q.cle;
	assign ADDR_LATCH_SEL = r_q.ale;
	assign WRITE_STROBE_N = r_q.we_n;
	// read strobe high for writes, guard held
	assign READ_STROBE_N = r_q.re_n;
	assign WRITE_GUARD_N = r_q.guard_n;
	assign IO_BUS_OUT = r_q.dout;
	assign IO_BUS_OE = r_q.oe;

endmodule : nhc_host

`default_nettype wire

// ==== verification/nhc_host_chk.sv ====
// Purpose: Pin protocol checks on the NAND host controller
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only top-level ports, bound below
`default_nettype none
module nhc_host_chk
	import nhc_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic CHIP_SELECT_N,
	input wire logic CMD_LATCH_SEL,
	input wire logic ADDR_LATCH_SEL,
	input wire logic WRITE_STROBE_N,
	input wire logic READ_STROBE_N,
	input wire logic WRITE_GUARD_N,
	input wire nhc_byte_type IO_BUS_OUT,
	input wire logic IO_BUS_OE,
	input wire logic READY_BUSY_N,
	input wire logic DEVICE_READY
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// Select, strobe and busy relations
	idle_float_a : assert property (CHIP_SELECT_N |-> !IO_BUS_OE)
		else $error("bus driven while deselected");
	write_sel_a : assert property (!WRITE_STROBE_N |-> !CHIP_SELECT_N && IO_BUS_OE && READ_STROBE_N)
		else $error("write strobe without select or drive");
	byte_hold_a : assert property ($rose(WRITE_STROBE_N) |-> IO_BUS_OE && $stable(IO_BUS_OUT))
		else $error("byte moved at write strobe rise");
	latch_excl_a : assert property (CMD_LATCH_SEL |-> !ADDR_LATCH_SEL)
		else $error("both latch selects high");
	data_guard_a : assert property ($fell(WRITE_STROBE_N) && !CMD_LATCH_SEL && !ADDR_LATCH_SEL
		|-> WRITE_GUARD_N)
		else $error("data cycle while guarded");
	we_pulse_a : assert property ($fell(WRITE_STROBE_N) |=> WRITE_STROBE_N)
		else $error("write strobe low too long");
	read_quiet_a : assert property (!READ_STROBE_N |-> WRITE_STROBE_N && !CMD_LATCH_SEL
		&& !ADDR_LATCH_SEL && !IO_BUS_OE)
		else $error("bus activity during read strobe");
	re_width_a : assert property ($fell(READ_STROBE_N) |-> !READ_STROBE_N [*4] ##1 READ_STROBE_N)
		else $error("read strobe width wrong");
	busy_seen_a : assert property ($fell(READY_BUSY_N) |-> ##[2:4] !DEVICE_READY)
		else $error("busy not reported");
endmodule : nhc_host_chk
bind nhc_host nhc_host_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .CHIP_SELECT_N(CHIP_SELECT_N),
	.CMD_LATCH_SEL(CMD_LATCH_SEL), .ADDR_LATCH_SEL(ADDR_LATCH_SEL),
	.WRITE_STROBE_N(WRITE_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
	.WRITE_GUARD_N(WRITE_GUARD_N), .IO_BUS_OUT(IO_BUS_OUT), .IO_BUS_OE(IO_BUS_OE),
	.READY_BUSY_N(READY_BUSY_N), .DEVICE_READY(DEVICE_READY));
`default_nettype wire

// ==== verification/nhc_nand_model.sv ====
// Purpose: Behavioural flash device on the far side of the host
// Assumes: Page byte is column xor a fixed pattern
// Notes: Undriven data lines show the inverse of the last byte
`default_nettype none
module nhc_nand_model
	import nhc_pkg::*;
#(
	parameter int READ_NS = 20,
	parameter int BUSY_NS = 2000
) (
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire nhc_byte_type io_in,
	output nhc_byte_type io_out,
	output logic busy_pd
);
	timeunit 1ns;
	timeprecision 100ps;
	nhc_byte_type cmd_reg, data_reg, io_q;
	nhc_byte_type addr_reg [5];
	int addr_cnt = 0;
	// Length of the last address phase, kept past the confirm command
	int n_addr = 0;
	int col = 0;
	int n_prog = 0;
	logic drive = 1'b0;
	logic plane;
	initial busy_pd = 1'b0;
	always @(posedge we_n) if (!ce_n && re_n) begin
		if (cle) begin
			cmd_reg = io_in;
			addr_cnt = 0;
			if ((io_in == 8'h10 && wp_n) || io_in == 8'h30) begin
				n_prog += int'(io_in == 8'h10);
				busy_pd = 1'b1;
				busy_pd <= #(BUSY_NS) 1'b0;
			end
		end else if (ale) begin
			if (addr_cnt < 5) addr_reg[addr_cnt] = io_in;
			addr_cnt++;
			n_addr = addr_cnt;
			if (addr_cnt == 2) col = {io_in[3:0], addr_reg[0]};
		end else if (wp_n) data_reg = io_in;
	end
	assign plane = addr_reg[2][6];
	// next byte after access delay; select checked late to avoid races
	always @(negedge re_n) begin
		#(READ_NS);
		if (!ce_n && !re_n) begin
			io_q = 8'(col) ^ 8'h5A;
			drive = 1'b1;
			col++;
		end
	end
	// float when deselected or strobe ends
	always @(posedge re_n or posedge ce_n) drive = 1'b0;
	assign io_out = drive ? io_q : ~io_q;
endmodule : nhc_nand_model
`default_nettype wire

// ==== verification/nhc_host_tb_top.sv ====
// Purpose: Self-checking bench for the NAND host controller
// Assumes: Flash model on the far side, pull-up on the busy line
// Notes: Table rows first, then reset and command-set cases
`default_nettype none
module nhc_host_tb_top
	import nhc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		nhc_op_type op;
		nhc_byte_type b;
		logic pe;
		logic keep;
		logic err;
		nhc_byte_type rd;
	} nhc_row_type;
	localparam nhc_row_type ROWS [15] = '{
		'{NHC_OP_CMD, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00}, '{NHC_OP_ADDR, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00},
		'{NHC_OP_CMD, 8'h30, 1'b1, 1'b0, 1'b0, 8'h00}, '{NHC_OP_WAIT, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00},
		'{NHC_OP_RDATA, 8'h00, 1'b1, 1'b1, 1'b0, 8'h21}, '{NHC_OP_RDATA, 8'h00, 1'b1, 1'b1, 1'b0, 8'h26},
		'{NHC_OP_RDATA, 8'h00, 1'b1, 1'b0, 1'b0, 8'h27}, '{NHC_OP_CMD, 8'h42, 1'b1, 1'b0, 1'b1, 8'h00},
		'{NHC_OP_CMD, 8'h80, 1'b0, 1'b0, 1'b1, 8'h00}, '{NHC_OP_WDATA, 8'hE1, 1'b0, 1'b0, 1'b1, 8'h00},
		'{NHC_OP_CMD, 8'h80, 1'b1, 1'b0, 1'b0, 8'h00}, '{NHC_OP_ADDR, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00},
		'{NHC_OP_WDATA, 8'h3C, 1'b1, 1'b0, 1'b0, 8'h00}, '{NHC_OP_CMD, 8'h10, 1'b1, 1'b0, 1'b0, 8'h00},
		'{NHC_OP_WAIT, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00}};
	logic CLOCK, RST_N, REQ_VALID, REQ_KEEP_SEL, PROGRAM_ENABLE, REQ_READY, RSP_VALID, RSP_ERR;
	logic DEVICE_READY, CHIP_SELECT_N, CMD_LATCH_SEL, ADDR_LATCH_SEL, WRITE_STROBE_N;
	logic READ_STROBE_N, WRITE_GUARD_N, IO_BUS_OE, busy_pd;
	nhc_op_type REQ_OP;
	nhc_byte_type REQ_BYTE, RSP_BYTE, IO_BUS_OUT, mdl_io;
	logic [NHC_COL_W-1:0] REQ_COLUMN;
	logic [NHC_ROW_W-1:0] REQ_ROW;
	wire nhc_byte_type bus_w;
	wire logic rb_w;
	int n_fail = 0;
	int cmp_count = 0;
	// Host owns the data lines while it drives them
	assign bus_w = IO_BUS_OE ? IO_BUS_OUT : mdl_io;
	assign rb_w = busy_pd ? 1'b0 : 1'b1;
	nhc_host u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
		.REQ_OP(REQ_OP), .REQ_BYTE(REQ_BYTE), .REQ_COLUMN(REQ_COLUMN), .REQ_ROW(REQ_ROW),
		.REQ_KEEP_SEL(REQ_KEEP_SEL), .PROGRAM_ENABLE(PROGRAM_ENABLE), .RSP_VALID(RSP_VALID),
		.RSP_ERR(RSP_ERR), .RSP_BYTE(RSP_BYTE), .DEVICE_READY(DEVICE_READY),
		.CHIP_SELECT_N(CHIP_SELECT_N), .CMD_LATCH_SEL(CMD_LATCH_SEL),
		.ADDR_LATCH_SEL(ADDR_LATCH_SEL), .WRITE_STROBE_N(WRITE_STROBE_N),
		.READ_STROBE_N(READ_STROBE_N), .WRITE_GUARD_N(WRITE_GUARD_N), .READY_BUSY_N(rb_w),
		.IO_BUS_IN(bus_w), .IO_BUS_OUT(IO_BUS_OUT), .IO_BUS_OE(IO_BUS_OE));
	nhc_nand_model u_mdl (.ce_n(CHIP_SELECT_N), .cle(CMD_LATCH_SEL), .ale(ADDR_LATCH_SEL),
		.we_n(WRITE_STROBE_N), .re_n(READ_STROBE_N), .wp_n(WRITE_GUARD_N), .io_in(bus_w),
		.io_out(mdl_io), .busy_pd(busy_pd));
	// Free-running 40 MHz clock
	initial begin
		CLOCK = 1'b0;
		forever #12.5 CLOCK = ~CLOCK;
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One request, bounded waits on ready and response
	task automatic do_req(input nhc_row_type r);
		int n;
		n = 0;
		PROGRAM_ENABLE = r.pe;
		REQ_OP = r.op;
		REQ_BYTE = r.b;
		REQ_KEEP_SEL = r.keep;
		@(negedge CLOCK);
		while (REQ_READY !== 1'b1 && n < 50) begin
			@(negedge CLOCK);
			n++;
		end
		REQ_VALID = 1'b1;
		@(negedge CLOCK);
		REQ_VALID = 1'b0;
		while (RSP_VALID !== 1'b1 && n < 2000) begin
			@(negedge CLOCK);
			n++;
		end
		chk(40'(RSP_VALID), 40'h1);
		chk(40'(RSP_ERR), 40'(r.err));
		if (r.op == NHC_OP_RDATA) chk(40'(RSP_BYTE), 40'(r.rd));
	endtask : do_req
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : complete_run
	// Watchdog well past the expected run length
	initial begin
		#(25 * 20000);
		$display("ERROR %0t watchdog expired", $time);
		n_fail++;
		complete_run();
	end
	// Table rows, then mid-run reset and every defined command
	initial begin
		{RST_N, REQ_VALID, REQ_KEEP_SEL, PROGRAM_ENABLE} = 4'h0;
		REQ_OP = NHC_OP_CMD;
		REQ_BYTE = 8'h00;
		// Address with plane bit set, distinct bytes in every cycle
		REQ_COLUMN = 12'hA7B;
		REQ_ROW = 18'h2C345;
		repeat (10) @(negedge CLOCK);
		RST_N = 1'b1;
		for (int i = 0; i < 15; i++) do_req(ROWS[i]);
		chk(40'(u_mdl.cmd_reg), 40'h10);
		chk(40'(u_mdl.data_reg), 40'h3C);
		chk(40'(u_mdl.n_prog), 40'h1);
		chk(40'(u_mdl.n_addr), 40'h5);
		chk(40'(u_mdl.plane), 40'h1);
		chk({u_mdl.addr_reg[0], u_mdl.addr_reg[1], u_mdl.addr_reg[2], u_mdl.addr_reg[3],
			u_mdl.addr_reg[4]}, 40'h7B0A45C302);
		REQ_OP = NHC_OP_RDATA;
		REQ_VALID = 1'b1;
		repeat (3) @(negedge CLOCK);
		RST_N = 1'b0;
		REQ_VALID = 1'b0;
		@(negedge CLOCK);
		chk(40'({CHIP_SELECT_N, READ_STROBE_N, WRITE_STROBE_N, IO_BUS_OE, RSP_VALID}), 40'h1C);
		RST_N = 1'b1;
		foreach (NHC_CMD_SET[i]) do_req('{NHC_OP_CMD, NHC_CMD_SET[i], 1'b1, 1'b0, 1'b0, 8'h00});
		complete_run();
	end
endmodule : nhc_host_tb_top
`default_nettype wire
